// ### dlsi_regs.svh
/*
 * register indices, field positions and reset values of the
 * data link slot inserter.
 * assumes: included by bare name from the design and bench files.
 */
`ifndef DLSI_REGS_SVH
`define DLSI_REGS_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define DLSI_IDX_L1_CTRL 10'h038
`define DLSI_IDX_L1_MASK 10'h039
`define DLSI_IDX_L2_CTRL 10'h03A
`define DLSI_IDX_L2_MASK 10'h03B
`define DLSI_IDX_L3_CTRL 10'h03C
`define DLSI_IDX_L3_MASK 10'h03D
`define DLSI_IDX_CONFIG 10'h03E
`define DLSI_IDX_STATUS 10'h03F

// ----------------------------------------------------------------
// control and config register fields
// ----------------------------------------------------------------
`define DLSI_CTRL_EVEN 7
`define DLSI_CTRL_ODD 6
`define DLSI_CTRL_AUTO 5
`define DLSI_CTRL_SLOT_MSB 4
`define DLSI_CTRL_SLOT_LSB 0
`define DLSI_CFG_E1 0

// ----------------------------------------------------------------
// reset values and control write mask
// ----------------------------------------------------------------
`define DLSI_L1_CTRL_RST 8'h20
`define DLSI_CTRL_RST 8'h00
`define DLSI_MASK_RST 8'h00
`define DLSI_CFG_RST 8'h00
`define DLSI_CTRL_WMASK 8'hDF

`endif

// ### dlsi_pkg.sv
/*
 * types shared by the data link slot inserter modules.
 * assumes: dlsi_regs.svh is on the include path.
 */
package dlsi_pkg;
	typedef logic [7:0] dlsi_byte_t;
	typedef logic [4:0] dlsi_slot_t;
	typedef logic [2:0] dlsi_bitpos_t;
	typedef logic [4:0] dlsi_frame_t;
	localparam int DLSI_LINKS = 3;
endpackage : dlsi_pkg

// ### dlsi_lane_if.sv
/*
 * per-link settings and stream position handed to one lane, and
 * the lane's insert decision coming back.
 * assumes: driven by dlsi_top, consumed by dlsi_lane.
 */
`timescale 1ns/100ps
interface dlsi_lane_if;
	import dlsi_pkg::*;
	dlsi_byte_t ctrl;
	dlsi_byte_t mask;
	dlsi_slot_t slot;
	dlsi_bitpos_t bit_pos;
	logic odd_frame;
	logic t1_mode;
	logic dl_pos;
	logic hit;
	modport lane (
		input ctrl,
		input mask,
		input slot,
		input bit_pos,
		input odd_frame,
		input t1_mode,
		input dl_pos,
		output hit
	);
	modport host (
		output ctrl,
		output mask,
		output slot,
		output bit_pos,
		output odd_frame,
		output t1_mode,
		output dl_pos,
		input hit
	);
endinterface : dlsi_lane_if

// ### dlsi_lane.sv
/*
 * insert decision of one link for the current bit of the stream.
 * assumes: settings and position stable while the bit enable is high;
 * purely combinational, the top registers the result.
 */
`timescale 1ns/100ps
`include "dlsi_regs.svh"
module dlsi_lane #(
	parameter bit HAS_AUTO = 1'b0
) (
	dlsi_lane_if.lane lif
);
	import dlsi_pkg::*;

	logic frame_ok;
	logic slot_ok;
	logic bit_ok;
	logic auto_ok;
	dlsi_bitpos_t mask_idx;

	// ----------------------------------------------------------------
	// decision
	// ----------------------------------------------------------------
	always_comb begin
		// even or odd enable gates slot insertion; auto bits bypass it
		// both clear: slot and mask are don't-care
		frame_ok = lif.odd_frame ? lif.ctrl[`DLSI_CTRL_ODD]
			: lif.ctrl[`DLSI_CTRL_EVEN];
		// binary slot field, T1 channel n is value n-1
		slot_ok = lif.slot ==
			lif.ctrl[`DLSI_CTRL_SLOT_MSB:`DLSI_CTRL_SLOT_LSB];
		// position 0 is sent first and maps to mask bit 7
		mask_idx = 3'h7 - lif.bit_pos;
		// full slot only when all eight mask bits set
		bit_ok = lif.mask[mask_idx];
		// framer-chosen data link bits, T1 only
		auto_ok = HAS_AUTO && lif.ctrl[`DLSI_CTRL_AUTO] &&
			lif.t1_mode && lif.dl_pos;
		lif.hit = (frame_ok & slot_ok & bit_ok) | auto_ok;
	end
endmodule : dlsi_lane

// ### dlsi_top.sv
/*
 * data link slot inserter: places three HDLC data links into chosen
 * bits of a chosen slot of the outgoing E1/T1 stream, with an APB
 * register slave.
 * assumes: the framer supplies one bit per tx_bit_en pulse with its
 * slot, bit position and frame number; all inputs synchronous to pclk.
 */
`timescale 1ns/100ps
`include "dlsi_regs.svh"

// Functional notes
// - binary slot field, T1 channels 1-24 as 0-23
// - slot ignored when both frame enables clear
// - set mask bits replace slot bits with link
// - whole slot only with all mask bits set
// - mask bit 7 first sent, bit 0 last
// - mask inert when both frame enables clear
// - even enable controls insertion into even frames
// - odd enable controls insertion into odd frames
// - frame parity from E1 0-15, T1 1-12/1-24
// - three independent links, own settings each
// - link 1 auto data link in T1 only
module dlsi_top #(
	parameter int ADDR_W = 12
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	input wire logic tx_bit_en,
	input wire logic tx_data_in,
	input wire dlsi_pkg::dlsi_slot_t tx_slot,
	input wire dlsi_pkg::dlsi_bitpos_t tx_bit_pos,
	input wire dlsi_pkg::dlsi_frame_t tx_frame_num,
	input wire logic tx_link1_dl_pos,
	input wire logic [2:0] link_data,
	output logic tx_data_out,
	output logic tx_data_en,
	output logic [2:0] link_bit_take
);
	import dlsi_pkg::*;

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	dlsi_byte_t ctrl_r [DLSI_LINKS];
	dlsi_byte_t mask_r [DLSI_LINKS];
	dlsi_byte_t cfg_r;
	dlsi_byte_t ins_cnt_r [DLSI_LINKS];
	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;
	logic tx_data_out_r;
	logic tx_data_en_r;
	logic [2:0] take_r;

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	logic [ADDR_W-3:0] idx;
	logic aligned;
	logic access;
	logic wr_done;
	logic mapped;
	logic [31:0] rd_nxt;

	assign idx = paddr[ADDR_W-1:2];
	assign aligned = paddr[1:0] == 2'h0;
	// one wait state: pready rises in the second access cycle
	assign access = psel & penable & ~pready_r;
	assign wr_done = psel & penable & pready_r & pwrite & mapped;

	always_comb begin
		mapped = aligned;
		rd_nxt = 32'h0;
		unique case (idx)
			(ADDR_W-2)'(`DLSI_IDX_L1_CTRL >> 2),
			`DLSI_IDX_L1_CTRL: rd_nxt = {24'h0, ctrl_r[0]};
			`DLSI_IDX_L1_MASK: rd_nxt = {24'h0, mask_r[0]};
			// unused bit 5 of links 2 and 3 reads zero
			`DLSI_IDX_L2_CTRL: rd_nxt = {24'h0, ctrl_r[1]};
			`DLSI_IDX_L2_MASK: rd_nxt = {24'h0, mask_r[1]};
			`DLSI_IDX_L3_CTRL: rd_nxt = {24'h0, ctrl_r[2]};
			`DLSI_IDX_L3_MASK: rd_nxt = {24'h0, mask_r[2]};
			`DLSI_IDX_CONFIG: rd_nxt = {24'h0, cfg_r};
			`DLSI_IDX_STATUS: rd_nxt = {8'h0, ins_cnt_r[2],
				ins_cnt_r[1], ins_cnt_r[0]};
			default: mapped = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r <= 1'b0;
			prdata_r <= 32'h0;
			pslverr_r <= 1'b0;
		end else begin
			pready_r <= access;
			prdata_r <= (access && !pwrite && mapped) ? rd_nxt : 32'h0;
			pslverr_r <= access & ~mapped;
		end
	end

	// ----------------------------------------------------------------
	// settings, one set per link
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r[0] <= `DLSI_L1_CTRL_RST;
			ctrl_r[1] <= `DLSI_CTRL_RST;
			ctrl_r[2] <= `DLSI_CTRL_RST;
			mask_r[0] <= `DLSI_MASK_RST;
			mask_r[1] <= `DLSI_MASK_RST;
			mask_r[2] <= `DLSI_MASK_RST;
			cfg_r <= `DLSI_CFG_RST;
		end else if (wr_done) begin
			// each link has its own control and mask
			unique case (idx)
				`DLSI_IDX_L1_CTRL: ctrl_r[0] <= pwdata[7:0];
				`DLSI_IDX_L1_MASK: mask_r[0] <= pwdata[7:0];
				`DLSI_IDX_L2_CTRL:
					ctrl_r[1] <= pwdata[7:0] & `DLSI_CTRL_WMASK;
				`DLSI_IDX_L2_MASK: mask_r[1] <= pwdata[7:0];
				`DLSI_IDX_L3_CTRL:
					ctrl_r[2] <= pwdata[7:0] & `DLSI_CTRL_WMASK;
				`DLSI_IDX_L3_MASK: mask_r[2] <= pwdata[7:0];
				`DLSI_IDX_CONFIG: cfg_r <= {7'h0, pwdata[`DLSI_CFG_E1]};
				default: cfg_r <= cfg_r;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// lanes
	// ----------------------------------------------------------------
	logic [2:0] hit;
	logic odd_frame;

	// framer numbers frames as the standard does; parity is bit 0
	assign odd_frame = tx_frame_num[0];

	genvar g;
	generate
		for (g = 0; g < DLSI_LINKS; g++) begin : g_lane
			dlsi_lane_if lif ();
			assign lif.ctrl = ctrl_r[g];
			assign lif.mask = mask_r[g];
			assign lif.slot = tx_slot;
			assign lif.bit_pos = tx_bit_pos;
			assign lif.odd_frame = odd_frame;
			assign lif.t1_mode = ~cfg_r[`DLSI_CFG_E1];
			assign lif.dl_pos = (g == 0) ? tx_link1_dl_pos : 1'b0;
			assign hit[g] = lif.hit;
			dlsi_lane #(
				.HAS_AUTO(g == 0)
			) u_lane (
				.lif(lif.lane)
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// insertion
	// ----------------------------------------------------------------
	logic [2:0] win;
	logic data_nxt;

	always_comb begin
		// lowest-numbered link owns a shared bit
		win = 3'h0;
		data_nxt = tx_data_in;
		if (hit[0]) begin
			win = 3'h1;
			data_nxt = link_data[0];
		end else if (hit[1]) begin
			win = 3'h2;
			data_nxt = link_data[1];
		end else if (hit[2]) begin
			win = 3'h4;
			data_nxt = link_data[2];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_data_out_r <= 1'b0;
			tx_data_en_r <= 1'b0;
		end else begin
			tx_data_en_r <= tx_bit_en;
			// untouched bits pass straight through
			if (tx_bit_en) begin
				tx_data_out_r <= data_nxt;
			end
		end
	end

	// link bit is sampled with the enable; the take pulse that follows
	// tells the transmitter to advance, so losers never lose a bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			take_r <= 3'h0;
		end else begin
			take_r <= tx_bit_en ? win : 3'h0;
		end
	end

	// inserted-bit counters, wrap at 256, shown in status
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ins_cnt_r[0] <= 8'h00;
			ins_cnt_r[1] <= 8'h00;
			ins_cnt_r[2] <= 8'h00;
		end else begin
			for (int i = 0; i < DLSI_LINKS; i++) begin
				if (take_r[i]) begin
					ins_cnt_r[i] <= ins_cnt_r[i] + 8'h01;
				end
			end
		end
	end

	assign pready = pready_r;
	assign prdata = prdata_r;
	assign pslverr = pslverr_r;
	assign tx_data_out = tx_data_out_r;
	assign tx_data_en = tx_data_en_r;
	assign link_bit_take = take_r;
endmodule : dlsi_top

// ### dlsi_top_props.sv
/* checker on the ports of the data link slot inserter top.
 assumes: bound to dlsi_top; one clock, async active-low reset. */
`timescale 1ns/100ps
module dlsi_top_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic tx_bit_en,
	input wire logic tx_data_in,
	input wire logic [2:0] link_data,
	input wire logic tx_data_out,
	input wire logic tx_data_en,
	input wire logic [2:0] link_bit_take
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_rdy_cause: assert property (pready |-> $past(psel && penable))
		else $error("pready outside access");
	a_rdy_pulse: assert property (pready |=> !pready)
		else $error("pready held");
	a_err_nodata: assert property (pslverr |-> pready && prdata == 0)
		else $error("bad error response");
	a_rd_idle: assert property (!pready |-> prdata == 0)
		else $error("prdata without pready");
	a_bit_follow: assert property (tx_bit_en |=> tx_data_en)
		else $error("bit not answered");
	a_bit_quiet: assert property (!tx_bit_en |=> !tx_data_en)
		else $error("spurious output bit");
	a_take_one: assert property ($onehot0(link_bit_take))
		else $error("two links took one bit");
	a_take_bit: assert property (|link_bit_take |-> tx_data_en)
		else $error("take without bit");
	a_take_data: assert property (|link_bit_take |->
		tx_data_out == |($past(link_data) & link_bit_take))
		else $error("inserted bit wrong");
	a_pass_data: assert property (tx_data_en && link_bit_take == 0 |->
		tx_data_out == $past(tx_data_in))
		else $error("passed bit wrong");
endmodule : dlsi_top_props
bind dlsi_top dlsi_top_props u_props (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pready(pready), .prdata(prdata),
	.pslverr(pslverr), .tx_bit_en(tx_bit_en), .tx_data_in(tx_data_in),
	.link_data(link_data), .tx_data_out(tx_data_out),
	.tx_data_en(tx_data_en), .link_bit_take(link_bit_take));

// ### dlsi_hdlc_src.sv
/* model of the three HDLC transmitters feeding link bits.
 assumes: take pulses come from dlsi_top on pclk. */
`timescale 1ns/100ps
module dlsi_hdlc_src (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [2:0] link_bit_take,
	output logic [2:0] link_data
);
	logic [7:0] pat_r [3];
	// distinct patterns so a wrong link shows up
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pat_r[0] <= 8'hA6;
			pat_r[1] <= 8'h3C;
			pat_r[2] <= 8'h95;
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (link_bit_take[i]) begin
					pat_r[i] <= {pat_r[i][6:0], pat_r[i][7]};
				end
			end
		end
	end
	assign link_data = {pat_r[2][7], pat_r[1][7], pat_r[0][7]};
endmodule : dlsi_hdlc_src

// ### test_dlsi_top.sv
/* self-checking bench of the data link slot inserter.
 assumes: dlsi_top, dlsi_hdlc_src and the checker are compiled. */
`timescale 1ns/100ps
`include "dlsi_regs.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
	$display("Error %s exp %0h got %0h", n, e, g); end end
module test_dlsi_top;
	import dlsi_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata;
	logic pready, pslverr, tx_bit_en = 0, tx_data_in = 0, dl_pos = 0;
	dlsi_slot_t tx_slot = 0;
	dlsi_bitpos_t tx_bit_pos = 0;
	dlsi_frame_t tx_frame_num = 0;
	logic [2:0] link_data, link_bit_take;
	logic tx_data_out, tx_data_en;
	int n_errors = 0, checks = 0;
	always #2.5 pclk = ~pclk;
	dlsi_top u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr),
		.tx_bit_en(tx_bit_en), .tx_data_in(tx_data_in), .tx_slot(tx_slot),
		.tx_bit_pos(tx_bit_pos), .tx_frame_num(tx_frame_num),
		.tx_link1_dl_pos(dl_pos), .link_data(link_data),
		.tx_data_out(tx_data_out), .tx_data_en(tx_data_en),
		.link_bit_take(link_bit_take));
	dlsi_hdlc_src u_src (.pclk(pclk), .presetn(presetn),
		.link_bit_take(link_bit_take), .link_data(link_data));
	task automatic apb(input logic w, input logic [9:0] idx,
		input logic [7:0] d, input logic e, output logic [31:0] r);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1;
		// wait for the answer at a rising edge; the watchdog ends a hang
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		`CHK("pslverr", e, pslverr)
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask : apb
	task automatic wr(input logic [9:0] idx, input logic [7:0] d);
		logic [31:0] r;
		apb(1, idx, d, 0, r);
	endtask : wr
	// one stream bit; din varies so pass-through is visible
	task automatic send(input dlsi_slot_t s, input dlsi_bitpos_t p,
		input dlsi_frame_t f, input logic dp, input logic [2:0] exp);
		logic [2:0] ld;
		logic din;
		din = p[0] ^ f[0] ^ s[0];
		tx_bit_en <= 1;
		tx_slot <= s;
		tx_bit_pos <= p;
		tx_frame_num <= f;
		dl_pos <= dp;
		tx_data_in <= din;
		@(negedge pclk);
		ld = link_data;
		@(posedge pclk);
		tx_bit_en <= 0;
		dl_pos <= 0;
		@(negedge pclk);
		`CHK("take", exp, link_bit_take)
		`CHK("out", (exp != 0) ? |(ld & exp) : din, tx_data_out)
		@(posedge pclk);
	endtask : send
	task automatic t_regs;
		logic [31:0] r;
		apb(0, `DLSI_IDX_L1_CTRL, 0, 0, r);
		`CHK("l1 ctrl", 32'h20, r)
		apb(0, `DLSI_IDX_L2_MASK, 0, 0, r);
		`CHK("l2 mask", 32'h0, r)
		wr(`DLSI_IDX_L2_CTRL, 8'hFF);
		apb(0, `DLSI_IDX_L2_CTRL, 0, 0, r);
		`CHK("l2 ctrl", 32'hDF, r)
		apb(0, 10'h00E, 0, 0, r);
		`CHK("l1 ctrl alias", 32'h20, r)
		apb(0, 10'h040, 0, 1, r);
		`CHK("unmapped", 32'h0, r)
	endtask : t_regs
	task automatic t_mask;
		wr(`DLSI_IDX_L2_CTRL, 8'h00);
		wr(`DLSI_IDX_L1_MASK, 8'h81);
		wr(`DLSI_IDX_L1_CTRL, 8'h85);
		for (int p = 0; p < 8; p++) begin
			send(5, p, 0, 0, {2'b0, p == 0 || p == 7});
		end
		send(5, 0, 1, 0, 3'b000);
		send(4, 0, 0, 0, 3'b000);
		wr(`DLSI_IDX_L1_MASK, 8'hFF);
		for (int p = 0; p < 8; p++) begin
			send(5, p, 2, 0, 3'b001);
		end
		wr(`DLSI_IDX_L1_CTRL, 8'h57);
		send(23, 3, 2, 0, 3'b000);
		send(23, 3, 15, 0, 3'b001);
	endtask : t_mask
	task automatic t_overlap;
		wr(`DLSI_IDX_L1_CTRL, 8'h09);
		wr(`DLSI_IDX_L2_CTRL, 8'hC9);
		wr(`DLSI_IDX_L2_MASK, 8'hF0);
		wr(`DLSI_IDX_L3_CTRL, 8'hC9);
		wr(`DLSI_IDX_L3_MASK, 8'hFF);
		send(9, 0, 0, 0, 3'b010);
		send(9, 7, 1, 0, 3'b100);
		send(9, 7, 1, 1, 3'b100);
	endtask : t_overlap
	task automatic t_auto;
		logic [31:0] r;
		wr(`DLSI_IDX_L1_CTRL, 8'h20);
		send(0, 0, 0, 1, 3'b001);
		send(0, 1, 0, 0, 3'b000);
		wr(`DLSI_IDX_CONFIG, 8'h01);
		send(0, 0, 0, 1, 3'b000);
		// link 1 took 12 bits, link 2 one, link 3 two over the whole run
		apb(0, `DLSI_IDX_STATUS, 0, 0, r);
		`CHK("status", 32'h0002010C, r)
	endtask : t_auto
	task automatic tally_and_finish;
		if (n_errors == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		t_regs;
		t_mask;
		t_overlap;
		t_auto;
		tally_and_finish;
	end
	initial begin
		repeat (5000) @(posedge pclk);
		n_errors++;
		tally_and_finish;
	end
endmodule : test_dlsi_top
